// ===== ook_modem_ctrl.sv
// mode, direction and carrier control of an on-off-keyed coax modem
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - both rate selects high: standby, transmitter off, modulated output quiet
// - in standby the receiver still filters the line and drives received data
// - in standby modulated output stays idle whatever the transmit bit does
// - start in idle: received data high, output quiet, direction low
// - idle goes receive on valid line signal, transmit on transmit bit low
// - receive or transmit held until sixteen bit times after last activity
// - in receive, received data follows every valid line signal
// - receive or transmit: carrier while transmit bit low, quiet while high
// - receive ends a time-out after the last received data rising edge
// - in transmit, received data stays high whatever the line does
// - transmit ends a time-out after the transmit bit returns high
// - receive, line below threshold: data high, direction high until time-out
// - receive, line above threshold past filter: data low, direction high
// - transmit: direction low throughout and after, received data high
// - time-out 1667 us slow, 417 us lo-only, 137 us hi set
// - direction leads the received data change by at least 270 ns
// - carrier is the 8.704 MHz reference divided by four
// - direction follows coax input activity to enable an rs-485 transceiver
// - rate code: 00 slow, lo 38.4k, hi 115k, both standby
// - noise filter 4 us at the slowest rate, 2 us otherwise
// - unconnected rate selects mean the longest time-out
module ook_modem_ctrl #(
  parameter int unsigned TOUT_SLOW_REF = ook_pkg::DIR_SLOW_REF,
  parameter int unsigned TOUT_MID_REF  = ook_pkg::DIR_MID_REF,
  parameter int unsigned TOUT_FAST_REF = ook_pkg::DIR_FAST_REF
) (
  input  wire logic        CLK_SYS_I,        // 100 mhz system clock
  input  wire logic        RST_N_I,          // sync reset, active low
  input  wire logic        RATE_SELECT_LO_I, // rate select, low bit
  input  wire logic        RATE_SELECT_HI_I, // rate select, high bit
  input  wire logic        TX_BIT_IN_I,      // transmit bit stream
  input  wire logic        LINE_I,           // line above threshold
  output logic             MODULATED_O,      // gated carrier
  output logic             RX_BIT_OUT_O,     // received bit stream
  output logic             DIR_O,            // rs-485 direction
  input  wire logic [11:0] PADDR_I,          // apb address
  input  wire logic        PSEL_I,           // apb select
  input  wire logic        PENABLE_I,        // apb enable
  input  wire logic        PWRITE_I,         // apb direction
  input  wire logic [31:0] PWDATA_I,         // apb write data
  input  wire logic [3:0]  PSTRB_I,          // apb byte strobes
  output logic             PREADY_O,         // apb ready
  output logic [31:0]      PRDATA_O,         // apb read data
  output logic             PSLVERR_O         // apb error
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  ook_pkg::ctrl_s                 ctrl_reg;
  ook_pkg::mode_e                 mode_reg;
  ook_pkg::mode_e                 mode_next;
  logic [ook_pkg::NCO_W-1:0]      nco_reg;
  logic [ook_pkg::NCO_W:0]        nco_sum;
  logic                           ref_tick;
  logic [ook_pkg::CAR_DIV_W-1:0]  car_reg;
  logic [1:0]                     rate_code;
  logic                           standby;
  logic [ook_pkg::TOUT_W-1:0]     tout_term;
  logic [ook_pkg::TOUT_W-1:0]     tout_reg;
  logic                           tout_clr;
  logic                           tout_done;
  logic [ook_pkg::NF_W-1:0]       nf_term;
  logic [ook_pkg::NF_W-1:0]       nf_reg;
  logic                           above_reg;
  logic [ook_pkg::SKEW_W-1:0]     skew_reg;
  logic                           skew_met;
  logic                           rx_reg;
  logic                           rx_next;
  logic                           dir_reg;
  logic                           mod_reg;
  logic [31:0]                    rdata_reg;
  ook_pkg::status_s               status;
  logic                           addr_hit;
  logic                           apb_access;
  logic                           tx_allowed;
  logic                           tx_start;
  logic                           carrier_on;
  logic                           line_new;
  logic                           nf_full;
  logic                           tout_full;
  logic                           rx_active;
  logic                           setup_phase;
  logic                           ctrl_hit;
  logic                           status_hit;
  logic                           ctrl_write;

  ////////////////////////////////////////////////////////////////////////////
  // rate selection

  // software override only replaces the pins; open pins are a board pulldown
  assign rate_code = ctrl_reg.override ? ctrl_reg.rate
                                       : {RATE_SELECT_HI_I, RATE_SELECT_LO_I};
  assign standby = (rate_code == ook_pkg::RATE_STANDBY);
  // standby stops only the driver; the receive path keeps running
  assign tx_allowed = !standby;
  // standby refuses a new transmit; one under way is only muted
  assign tx_start = !TX_BIT_IN_I && tx_allowed;

  always_comb
  begin
    case (rate_code)
      ook_pkg::RATE_9K6:  tout_term = ook_pkg::TOUT_W'(TOUT_SLOW_REF);
      ook_pkg::RATE_38K4: tout_term = ook_pkg::TOUT_W'(TOUT_MID_REF);
      default:            tout_term = ook_pkg::TOUT_W'(TOUT_FAST_REF);
    endcase
  end

  // standby shares the fast filter and the shortest time-out
  assign nf_term = (rate_code == ook_pkg::RATE_9K6)
                   ? ook_pkg::NF_W'(ook_pkg::NF_SLOW_CYC)
                   : ook_pkg::NF_W'(ook_pkg::NF_FAST_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // reference tick and carrier

  // phase accumulator gives the 8.704 mhz reference as a tick on the clock
  // each tick jitters by one clock; the mean rate is exact to 32 bits
  assign nco_sum = {1'b0, nco_reg} + {1'b0, ook_pkg::NCO_INC};
  assign ref_tick = nco_sum[ook_pkg::NCO_W];

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      nco_reg <= '0;
    else
      nco_reg <= nco_sum[ook_pkg::NCO_W-1:0];
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      car_reg <= '0;
    else if (ref_tick)
      car_reg <= car_reg + 2'h1;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      mod_reg <= 1'b0;
    else
      mod_reg <= car_reg[ook_pkg::CAR_DIV_W-1] && carrier_on;
  end

  // carrier only in a live mode, transmit bit low and driver enabled
  assign carrier_on = !TX_BIT_IN_I
                      && (mode_reg != ook_pkg::MODE_IDLE)
                      && tx_allowed;

  ////////////////////////////////////////////////////////////////////////////
  // receive noise filter

  assign line_new = (LINE_I != above_reg);
  assign nf_full = (nf_reg >= nf_term - 10'h001);

  // line must hold a new level for the whole filter time to be taken
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      nf_reg <= '0;
      above_reg <= 1'b0;
    end
    else if (!line_new)
      nf_reg <= '0;
    else if (nf_full)
    begin
      nf_reg <= '0;
      above_reg <= LINE_I;
    end
    else
      nf_reg <= nf_reg + 10'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction time-out

  // a line still above threshold counts as receive activity, so the
  // time-out cannot end receive while a zero bit is being taken
  assign rx_active = !rx_reg || above_reg;

  always_comb
  begin
    case (mode_reg)
      ook_pkg::MODE_RECEIVE:  tout_clr = rx_active;
      ook_pkg::MODE_TRANSMIT: tout_clr = !TX_BIT_IN_I;
      default:                tout_clr = 1'b1;
    endcase
  end

  assign tout_full = (tout_reg >= tout_term - 16'h0001);
  assign tout_done = ref_tick && !tout_clr
                     && tout_full;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      tout_reg <= '0;
    else if (tout_clr || tout_done)
      tout_reg <= '0;
    else if (ref_tick)
      tout_reg <= tout_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode machine

  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      ook_pkg::MODE_IDLE:
      begin
        // a line signal wins over a simultaneous transmit start
        if (above_reg)
          mode_next = ook_pkg::MODE_RECEIVE;
        else if (tx_start)
          mode_next = ook_pkg::MODE_TRANSMIT;
      end
      ook_pkg::MODE_RECEIVE,
      ook_pkg::MODE_TRANSMIT:
      begin
        if (tout_done)
          mode_next = ook_pkg::MODE_IDLE;
      end
      default: mode_next = ook_pkg::MODE_IDLE;
    endcase
  end

  // standby leaves the mode alone; only a new transmit is refused
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      mode_reg <= ook_pkg::MODE_IDLE;
    else
      mode_reg <= mode_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction and received data

  // taken from the next mode so direction moves with the mode itself
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      dir_reg <= 1'b0;
    else
      dir_reg <= (mode_next == ook_pkg::MODE_RECEIVE);
  end

  // counts how long direction has been high, so data never moves first
  // saturates, so a long message never wraps it back under the lead
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I || !dir_reg)
      skew_reg <= '0;
    else if (!skew_met)
      skew_reg <= skew_reg + 6'h01;
  end

  assign skew_met = (skew_reg >= ook_pkg::SKEW_W'(ook_pkg::SKEW_CYC));

  // received data falls only once direction has led it by the skew
  always_comb
  begin
    rx_next = 1'b1;
    case (mode_reg)
      ook_pkg::MODE_RECEIVE:
      begin
        if (!above_reg)
          rx_next = 1'b1;
        else if (skew_met)
          rx_next = 1'b0;
        else
          rx_next = rx_reg;
      end
      ook_pkg::MODE_TRANSMIT: rx_next = 1'b1;
      default:                rx_next = 1'b1;
    endcase
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      rx_reg <= 1'b1;
    else
      rx_reg <= rx_next;
  end

  assign MODULATED_O = mod_reg;
  assign RX_BIT_OUT_O = rx_reg;
  assign DIR_O = dir_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign status = '{line_above: above_reg, standby: standby, rx_bit: rx_reg,
                    dir: dir_reg, mode: mode_reg};
  assign ctrl_hit = (PADDR_I == ook_pkg::ADDR_CTRL);
  assign status_hit = (PADDR_I == ook_pkg::ADDR_STATUS);
  assign addr_hit = ctrl_hit || status_hit;
  assign apb_access = PSEL_I && PENABLE_I;
  assign setup_phase = PSEL_I && !PENABLE_I;
  // status writes are dropped without an error; only unmapped addresses err
  // only byte lane 0 holds control bits, so its strobe gates the write
  assign ctrl_write = apb_access && PWRITE_I && PSTRB_I[0] && ctrl_hit;

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_access && !addr_hit;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      ctrl_reg <= ook_pkg::CTRL_RESET;
    else if (ctrl_write)
      ctrl_reg <= ook_pkg::ctrl_s'(PWDATA_I[ook_pkg::CTRL_W-1:0]);
  end

  // read data is caught in the setup cycle so it stands through access
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      rdata_reg <= '0;
    else if (setup_phase)
    begin
      if (ctrl_hit)
        rdata_reg <= {29'h0, ctrl_reg};
      else if (status_hit)
        rdata_reg <= {26'h0, status};
      else
        rdata_reg <= '0;
    end
  end

  assign PRDATA_O = rdata_reg;

endmodule

// ===== ook_pkg.sv
// shared constants, codes and register layouts for the ook modem control
package ook_pkg;

  // clocking: system clock and the reference that the carrier comes from
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned REF_HZ = 8_704_000;
  localparam int unsigned NCO_W = 32;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((64'(REF_HZ) << NCO_W) / 64'(CLK_HZ));
  localparam int unsigned CAR_DIV_W = 2;

  // direction active durations, in microseconds
  localparam int unsigned DIR_SLOW_US = 1667;
  localparam int unsigned DIR_MID_US = 417;
  localparam int unsigned DIR_FAST_US = 137;
  // same durations as reference ticks, rounded down (typical figures)
  localparam int unsigned DIR_SLOW_REF =
    int'(64'(DIR_SLOW_US) * 64'(REF_HZ) / 64'd1_000_000);
  localparam int unsigned DIR_MID_REF =
    int'(64'(DIR_MID_US) * 64'(REF_HZ) / 64'd1_000_000);
  localparam int unsigned DIR_FAST_REF =
    int'(64'(DIR_FAST_US) * 64'(REF_HZ) / 64'd1_000_000);
  localparam int unsigned TOUT_W = 16;

  // receive noise filter times
  localparam int unsigned NF_SLOW_US = 4;
  localparam int unsigned NF_FAST_US = 2;
  localparam int unsigned NF_SLOW_CYC = NF_SLOW_US * (CLK_HZ / 1_000_000);
  localparam int unsigned NF_FAST_CYC = NF_FAST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned NF_W = 10;

  // least lead of direction over received data, rounded up
  localparam int unsigned SKEW_NS = 270;
  localparam int unsigned SKEW_CYC =
    (SKEW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SKEW_W = 6;

  // rate select code {hi, lo}
  localparam logic [1:0] RATE_9K6 = 2'h0;
  localparam logic [1:0] RATE_38K4 = 2'h1;
  localparam logic [1:0] RATE_115K = 2'h2;
  localparam logic [1:0] RATE_STANDBY = 2'h3;

  // apb register map
  localparam int unsigned APB_AW = 12;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_RECEIVE,
    MODE_TRANSMIT
  } mode_e;

  // control register, bit 0 override, bits 2:1 rate code
  typedef struct packed {
    logic [1:0] rate;
    logic       override;
  } ctrl_s;
  localparam ctrl_s CTRL_RESET = '{rate: 2'h0, override: 1'b0};
  localparam int unsigned CTRL_W = 3;

  // status register, bits 1:0 mode up to bit 5 filtered line
  typedef struct packed {
    logic       line_above;
    logic       standby;
    logic       rx_bit;
    logic       dir;
    logic [1:0] mode;
  } status_s;
  localparam int unsigned STATUS_W = 6;

endpackage

// ===== ook_modem_ctrl_sva.sv
// assertions on the ook modem control pins and apb answers
`timescale 1ns/1ps
module ook_modem_ctrl_sva (
  input wire logic        CLK_SYS_I,        // clock
  input wire logic        RST_N_I,          // reset
  input wire logic        RATE_SELECT_LO_I, // rate lo
  input wire logic        RATE_SELECT_HI_I, // rate hi
  input wire logic        TX_BIT_IN_I,      // tx bit
  input wire logic        LINE_I,           // line level
  input wire logic        MODULATED_O,      // carrier
  input wire logic        RX_BIT_OUT_O,     // rx bit
  input wire logic        DIR_O,            // direction
  input wire logic [11:0] PADDR_I,          // address
  input wire logic        PSEL_I,           // select
  input wire logic        PENABLE_I,        // enable
  input wire logic        PREADY_O,         // ready
  input wire logic        PSLVERR_O         // error
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  logic [9:0] run;
  logic       line_d;
  logic       stby;
  logic       slow;
  assign stby = RATE_SELECT_LO_I & RATE_SELECT_HI_I;
  assign slow = !RATE_SELECT_LO_I & !RATE_SELECT_HI_I;
  // cycles the line level has stood, saturating
  always_ff @(posedge CLK_SYS_I)
  begin
    line_d <= LINE_I;
    run <= (LINE_I != line_d) ? 10'h000 : ((&run) ? run : run + 10'h001);
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_standby_quiet: assert property (stby [*3] |-> !MODULATED_O)
    else $error("carrier seen in standby");
  chk_idle_rx_high: assert property (!DIR_O && !stby |-> RX_BIT_OUT_O)
    else $error("received bit low while direction low");
  chk_dir_lead: assert property
    ($fell(RX_BIT_OUT_O) && !stby |-> DIR_O && $past(DIR_O, 27))
    else $error("direction did not lead received bit");
  // small slack on the filter count covers register stages
  chk_rx_filter: assert property ($changed(RX_BIT_OUT_O) |->
    run >= (slow ? ook_pkg::NF_SLOW_CYC - 5 : ook_pkg::NF_FAST_CYC - 5))
    else $error("received bit changed before filter time");
  chk_tx_quiet: assert property (TX_BIT_IN_I [*3] |-> !MODULATED_O)
    else $error("carrier while transmit bit high");
  chk_dir_fall: assert property
    ($fell(DIR_O) |-> RX_BIT_OUT_O && $past(RX_BIT_OUT_O, 40))
    else $error("direction fell too soon after received data");
  chk_dir_cause: assert property ($rose(DIR_O) |-> $past(LINE_I))
    else $error("direction rose without line activity");
  chk_tx_dir_low: assert property
    (!TX_BIT_IN_I && !DIR_O && !stby |=> !DIR_O)
    else $error("direction rose during transmit");
  chk_apb_answer: assert property (PSEL_I && PENABLE_I |-> PREADY_O &&
    PSLVERR_O == (PADDR_I != ook_pkg::ADDR_CTRL &&
    PADDR_I != ook_pkg::ADDR_STATUS))
    else $error("apb ready or error wrong");
  cov_rx_zero: cover property ($fell(RX_BIT_OUT_O) && DIR_O);
  cov_carrier: cover property ($rose(MODULATED_O) && !TX_BIT_IN_I);
  cov_stby_rx: cover property (stby && $fell(RX_BIT_OUT_O));
endmodule
bind ook_modem_ctrl ook_modem_ctrl_sva u_ook_modem_ctrl_sva (
  .CLK_SYS_I, .RST_N_I, .RATE_SELECT_LO_I, .RATE_SELECT_HI_I, .TX_BIT_IN_I,
  .LINE_I, .MODULATED_O, .RX_BIT_OUT_O, .DIR_O, .PADDR_I, .PSEL_I,
  .PENABLE_I, .PREADY_O, .PSLVERR_O);

// ===== ook_far_side.sv
// far side model: serial controller transmit bit and coax line level
`timescale 1ns/1ps
module ook_far_side (
  input  wire logic clk_i,   // system clock
  input  wire logic dir_i,   // direction from modem
  output logic      line_o,  // line above threshold
  output logic      tx_bit_o // transmit bit, low sends
);
  initial
  begin
    line_o = 1'b0;
    tx_bit_o = 1'b1;
  end
  // carrier burst of n cycles seen on the line
  task automatic burst(input int n);
    @(posedge clk_i);
    line_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b0;
  endtask
  // zero bit of n cycles; never starts while the modem receives
  task automatic send(input int n);
    @(posedge clk_i);
    while (dir_i !== 1'b0)
      @(posedge clk_i);
    tx_bit_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    tx_bit_o <= 1'b1;
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the ook modem control block
`timescale 1ns/1ps
module tb;
  logic        clk, rst_n, rlo, rhi, line, tx_bit, mod, rx, dir, mod_d;
  logic        psel, pen, pwr, pready, pslverr, err;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, q;
  int          bad_count, n_tests, rises;
  ook_modem_ctrl #(.TOUT_SLOW_REF(20), .TOUT_MID_REF(10), .TOUT_FAST_REF(5))
  u_ook_modem_ctrl (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .RATE_SELECT_LO_I(rlo), .RATE_SELECT_HI_I(rhi), .TX_BIT_IN_I(tx_bit),
    .LINE_I(line), .MODULATED_O(mod), .RX_BIT_OUT_O(rx), .DIR_O(dir),
    .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr));
  ook_far_side u_ook_far_side (.clk_i(clk), .dir_i(dir), .line_o(line),
    .tx_bit_o(tx_bit));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    mod_d <= mod;
    if (mod === 1'b1 && mod_d === 1'b0)
      rises++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(ook_pkg::ADDR_CTRL, 1'b1, 32'h0000_0002);
    apb(ook_pkg::ADDR_CTRL, 1'b0, 32'h0);
    check("ctrl", q, 32'h0000_0002);
    apb(ook_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check("status idle", q, 32'h0000_0008);
    apb(12'h010, 1'b0, 32'h0);
    check("unmapped", q, 32'h0);
    check("unmapped err", err, 1'b1);
    pstrb <= 4'hE;
    apb(ook_pkg::ADDR_CTRL, 1'b1, 32'h0000_0007);
    check("strobe err", err, 1'b0);
    pstrb <= 4'hF;
    apb(ook_pkg::ADDR_CTRL, 1'b0, 32'h0);
    check("ctrl strobe", q, 32'h0000_0002);
    apb(ook_pkg::ADDR_CTRL, 1'b1, 32'h0000_0007);
    apb(ook_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check("override stby", q, 32'h0000_0018);
    apb(ook_pkg::ADDR_CTRL, 1'b1, 32'h0);
  endtask
  // a burst shorter than the slow filter must leave everything idle
  task automatic t_glitch();
    u_ook_far_side.burst(300);
    cyc(2);
    check("glitch rx", rx, 1'b1);
    check("glitch dir", dir, 1'b0);
  endtask
  task automatic t_rx();
    int c;
    real e;
    e = ook_pkg::NF_SLOW_CYC + 20.0 * ook_pkg::CLK_HZ / ook_pkg::REF_HZ;
    fork
      u_ook_far_side.burst(600);
      begin
        cyc(500);
        check("rx zero", rx, 1'b0);
        check("dir rx", dir, 1'b1);
      end
    join
    cyc(390);
    check("rx held", rx, 1'b0);
    cyc(20);
    check("rx one", rx, 1'b1);
    check("dir held", dir, 1'b1);
    c = 410;
    while (dir !== 1'b0 && c < 3000)
    begin
      cyc(1);
      c++;
    end
    check("rx timeout", c >= e - 10 && c <= e + 10, 1'b1);
  endtask
  task automatic t_tx();
    int r0;
    realtime t0;
    real e;
    @(posedge clk);
    rlo <= 1'b1;
    fork
      u_ook_far_side.send(2000);
      begin
        cyc(50);
        u_ook_far_side.burst(600);
        cyc(1);
        check("tx rx line", rx, 1'b1);
      end
      begin
        cyc(100);
        r0 = rises;
        cyc(1840);
        e = 1840.0 * (ook_pkg::REF_HZ / 4) / ook_pkg::CLK_HZ;
        check("carrier", rises - r0 >= e - 1.5 && rises - r0 <= e + 1.5,
          1'b1);
        check("tx rx", rx, 1'b1);
        check("tx dir", dir, 1'b0);
      end
    join
    t0 = $realtime;
    apb(ook_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check("mode tx", q[1:0], 2'h2);
    while (q[1:0] !== 2'h0 && $realtime - t0 < 5000)
      apb(ook_pkg::ADDR_STATUS, 1'b0, 32'h0);
    e = 10.0 * ook_pkg::CLK_HZ / ook_pkg::REF_HZ;
    check("tx timeout", ($realtime - t0) / 10 <= e + 12 &&
      ($realtime - t0) / 10 >= e - 8, 1'b1);
  endtask
  task automatic t_stby();
    int r0;
    rhi <= 1'b1;
    cyc(5);
    r0 = rises;
    u_ook_far_side.send(300);
    check("stby quiet", rises - r0, 0);
    fork
      u_ook_far_side.burst(400);
      begin
        cyc(150);
        check("stby filt", rx, 1'b1);
        cyc(150);
        check("stby rx", rx, 1'b0);
      end
    join
    cyc(300);
    check("stby rx one", rx, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    rlo = 1'b0;
    rhi = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    check("idle rx", rx, 1'b1);
    check("idle dir", dir, 1'b0);
    check("idle mod", mod, 1'b0);
    t_regs();
    t_glitch();
    t_rx();
    t_tx();
    t_stby();
    summarize();
  end
  initial
  begin
    #200_000;
    bad_count++;
    summarize();
  end
endmodule
